// >>> verilog/vui_map.vh
// Overview of operation
// [R1] Line 2 takes port3_line1 edges, selectable rise, fall or both (bits 7,6 both set); vector 4,5.
// [R2] Lines 3,4,5 take sixteen/eight-bit timer and low-voltage requests; vectors 6..11.
// [R3] Simultaneous pending requests are resolved by a priority-register-driven encoder.
// [R4] A grant starts the interrupt machine cycle and disables further interrupts.
// [R5] The machine cycle saves program counter and status flags before branching.
// [R6] Two vector bytes, high then low, form the 16-bit service address.
// [R7] Pending bits stay readable while masked, for polled operation.
// [R8] comparator_one_input feeds line 2; comparator_two_input feeds line 0.
// [R9] Request register bits 7,6 pick edges of lines 2 and 0.
// [R10] Software can read current levels of the edge-triggered pins.
// [R11] The priority register is write-only; reads never return its value.
// [R12] Line 0 takes port3_line2 edges, selectable rise, fall or both (bits 7,6 both set); vector 0,1.
// [R13] Line 1 takes port3_line3 falling edges only; vector 2,3.
// [R14] Entering the machine cycle clears the granted request's pending bit.
`ifndef VUI_MAP_VH
`define VUI_MAP_VH

// Register indices; byte address is index times four
`define VUI_IDX_PRIO       10'h0F9
`define VUI_IDX_IRQ        10'h0FA
`define VUI_IDX_REQ_EN     10'h100
`define VUI_IDX_CTRL       10'h101
`define VUI_IDX_LEVEL      10'h102
`define VUI_IDX_INT_STAT   10'h103
`define VUI_IDX_INT_MASK   10'h104

// Field positions
`define VUI_IRQ_SEL2_BIT   7
`define VUI_IRQ_SEL0_BIT   6
`define VUI_CTRL_CMP1_BIT  0
`define VUI_CTRL_CMP2_BIT  1
`define VUI_EV_ENTRY_BIT   0
`define VUI_EV_JUMP_BIT    1
`define VUI_EV_OVERRUN_BIT 2

// Reset values
`define VUI_PRIO_RST       8'h00
`define VUI_IRQ_RST        8'h00
`define VUI_REQ_EN_RST     6'h00
`define VUI_CTRL_RST       2'h0
`define VUI_INT_MASK_RST   3'h0
`define VUI_INT_STAT_RST   3'h0

// Bus answers
`define VUI_RESP_OKAY      2'h0
`define VUI_RESP_SLVERR    2'h2

`endif

// >>> verilog/vui_edge_det.v
`timescale 1ns/10ps
`default_nettype none
module vui_edge_det (
  input  wire clk,
  input  wire nrst,
  input  wire level,
  input  wire rise_en,
  input  wire fall_en,
  output wire pulse
);
  reg prev_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  assign pulse = (rise_en & level & ~prev_r) | (fall_en & ~level & prev_r);
endmodule
`default_nettype wire

// >>> verilog/vui_prio_enc.v
`timescale 1ns/10ps
`default_nettype none
module vui_prio_enc (
  input  wire [5:0] req,
  input  wire [7:0] prio,
  output reg        valid,
  output reg  [2:0] idx
);
  reg [3:0] start;
  reg [3:0] pos;
  integer   k;

  // Rotating order: search starts at line prio[2:0] (line 0 for 6 and 7), upward, wrapping at 6
  always @* begin
    start = (prio[2:0] > 3'd5) ? 4'd0 : {1'b0, prio[2:0]};
    valid = 1'b0;
    idx   = 3'd0;
    pos   = 4'd0;
    for (k = 5; k >= 0; k = k - 1) begin
      pos = start + k[3:0];
      if (pos > 4'd5) begin
        pos = pos - 4'd6;
      end
      if (req[pos[2:0]]) begin
        valid = 1'b1;
        idx   = pos[2:0];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/vui_top.v
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "vui_map.vh"
module vui_top (
  input  wire        clk,
  input  wire        nrst,
  // Pins, asynchronous
  input  wire        port3_line1,
  input  wire        port3_line2,
  input  wire        port3_line3,
  input  wire        comparator_one_input,
  input  wire        comparator_two_input,
  // Internal request pulses, same clock
  input  wire        sixteen_bit_timer,
  input  wire        eight_bit_timer,
  input  wire        low_voltage_detector,
  // Core sequencer
  input  wire        core_gie,
  input  wire        core_ready,
  input  wire        core_save_done,
  input  wire        pm_valid,
  input  wire [7:0]  pm_data,
  output reg         int_cycle_r,
  output reg         gie_clr_r,
  output reg         save_req_r,
  output reg         pm_rd_r,
  output reg  [15:0] pm_addr_r,
  output reg         jump_r,
  output reg  [15:0] jump_addr_r,
  output reg  [2:0]  grant_idx_r,
  output reg         irq_r,
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_SAVE = 5'b00010;
  localparam [4:0] ST_FHI  = 5'b00100;
  localparam [4:0] ST_FLO  = 5'b01000;
  localparam [4:0] ST_JUMP = 5'b10000;

  reg  [4:0]  state_r;
  reg  [4:0]  sync1_r;
  reg  [4:0]  sync2_r;
  reg  [7:0]  prio_r;
  reg  [7:0]  irq_reg_r;
  reg  [5:0]  req_en_r;
  reg  [1:0]  ctrl_r;
  reg  [2:0]  int_stat_r;
  reg  [2:0]  int_mask_r;
  reg         aw_got_r;
  reg         w_got_r;
  reg  [9:0]  aw_idx_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;

  reg  [5:0]  pend_nxt;
  reg  [2:0]  stat_nxt;
  reg  [2:0]  mask_nxt;
  reg  [31:0] rdata_nxt;
  reg         rmapped;

  wire [5:0]  set_v;
  wire [5:0]  entry_clr;
  wire        line2_lvl;
  wire        line0_lvl;
  wire        edge0;
  wire        edge1;
  wire        edge2;
  wire        enc_valid;
  wire [2:0]  enc_idx;
  wire        rise2;
  wire        fall2;
  wire        rise0;
  wire        fall0;
  wire        grant;
  wire        jump_done;
  wire        do_write;
  wire        wr_lane0;
  wire [9:0]  ar_idx;
  wire        mapped_w;

  // Two-stage synchronisers: {cmp2, cmp1, line3, line2, line1}
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= {comparator_two_input, comparator_one_input,
                  port3_line3, port3_line2, port3_line1};
      sync2_r <= sync1_r;
    end
  end

  // Edge selection from request register bits 7 and 6
  assign rise2 = irq_reg_r[`VUI_IRQ_SEL2_BIT];  // see [R9]
  assign fall2 = ~irq_reg_r[`VUI_IRQ_SEL2_BIT] | irq_reg_r[`VUI_IRQ_SEL0_BIT];  // see [R9]
  assign rise0 = irq_reg_r[`VUI_IRQ_SEL0_BIT];  // see [R9]
  assign fall0 = ~irq_reg_r[`VUI_IRQ_SEL0_BIT] | irq_reg_r[`VUI_IRQ_SEL2_BIT];  // see [R9]

  // Comparator sources replace the port pins when selected
  assign line2_lvl = ctrl_r[`VUI_CTRL_CMP1_BIT] ? sync2_r[3] : sync2_r[0];  // see [R8]
  assign line0_lvl = ctrl_r[`VUI_CTRL_CMP2_BIT] ? sync2_r[4] : sync2_r[1];  // see [R8]

  vui_edge_det u_edge0 (
    .clk     (clk),
    .nrst    (nrst),
    .level   (line0_lvl),
    .rise_en (rise0),
    .fall_en (fall0),
    .pulse   (edge0)
  );  // see [R12]

  vui_edge_det u_edge1 (
    .clk     (clk),
    .nrst    (nrst),
    .level   (sync2_r[2]),
    .rise_en (1'b0),
    .fall_en (1'b1),
    .pulse   (edge1)
  );  // see [R13]

  vui_edge_det u_edge2 (
    .clk     (clk),
    .nrst    (nrst),
    .level   (line2_lvl),
    .rise_en (rise2),
    .fall_en (fall2),
    .pulse   (edge2)
  );  // see [R1]

  assign set_v = {low_voltage_detector, eight_bit_timer, sixteen_bit_timer,
                  edge2, edge1, edge0};  // see [R2]

  vui_prio_enc u_enc (
    .req   (irq_reg_r[5:0] & req_en_r),
    .prio  (prio_r),
    .valid (enc_valid),
    .idx   (enc_idx)
  );  // see [R3]

  assign grant     = state_r[0] & enc_valid & core_gie & core_ready;  // see [R4]
  assign entry_clr = grant ? (6'h01 << enc_idx) : 6'h00;
  assign jump_done = state_r[3] & pm_valid;

  // Bus write path
  assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_lane0 = do_write & wstrb_r[0];
  assign mapped_w = (aw_idx_r == `VUI_IDX_PRIO) | (aw_idx_r == `VUI_IDX_IRQ) |
                    (aw_idx_r == `VUI_IDX_REQ_EN) | (aw_idx_r == `VUI_IDX_CTRL) |
                    (aw_idx_r == `VUI_IDX_LEVEL) | (aw_idx_r == `VUI_IDX_INT_STAT) |
                    (aw_idx_r == `VUI_IDX_INT_MASK);
  assign ar_idx   = s_axi_araddr[11:2];

  // Pending bits: hardware set wins over software write and entry clear
  always @* begin
    pend_nxt = irq_reg_r[5:0];
    if (wr_lane0 && aw_idx_r == `VUI_IDX_IRQ) begin
      pend_nxt = wdata_r[5:0];
    end
    pend_nxt = (pend_nxt & ~entry_clr) | set_v;  // see [R14]
  end

  // Event status, write one to clear, set wins
  always @* begin
    stat_nxt = int_stat_r;
    mask_nxt = int_mask_r;
    if (wr_lane0 && aw_idx_r == `VUI_IDX_INT_STAT) begin
      stat_nxt = stat_nxt & ~wdata_r[2:0];
    end
    if (wr_lane0 && aw_idx_r == `VUI_IDX_INT_MASK) begin
      mask_nxt = wdata_r[2:0];
    end
    if (grant) begin
      stat_nxt[`VUI_EV_ENTRY_BIT] = 1'b1;
    end
    if (jump_done) begin
      stat_nxt[`VUI_EV_JUMP_BIT] = 1'b1;
    end
    if (|(set_v & irq_reg_r[5:0])) begin
      stat_nxt[`VUI_EV_OVERRUN_BIT] = 1'b1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg_r  <= `VUI_IRQ_RST;
      prio_r     <= `VUI_PRIO_RST;
      req_en_r   <= `VUI_REQ_EN_RST;
      ctrl_r     <= `VUI_CTRL_RST;
      int_stat_r <= `VUI_INT_STAT_RST;
      int_mask_r <= `VUI_INT_MASK_RST;
      irq_r      <= 1'b0;
    end else begin
      irq_reg_r[5:0] <= pend_nxt;  // see [R7]
      int_stat_r     <= stat_nxt;
      int_mask_r     <= mask_nxt;
      irq_r          <= |(stat_nxt & mask_nxt);
      if (wr_lane0) begin
        if (aw_idx_r == `VUI_IDX_IRQ) begin
          irq_reg_r[7:6] <= wdata_r[7:6];  // see [R9]
        end
        if (aw_idx_r == `VUI_IDX_PRIO) begin
          prio_r <= wdata_r[7:0];  // see [R3]
        end
        if (aw_idx_r == `VUI_IDX_REQ_EN) begin
          req_en_r <= wdata_r[5:0];
        end
        if (aw_idx_r == `VUI_IDX_CTRL) begin
          ctrl_r <= wdata_r[1:0];
        end
      end
    end
  end

  // Interrupt machine cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= ST_IDLE;
      int_cycle_r <= 1'b0;
      gie_clr_r   <= 1'b0;
      save_req_r  <= 1'b0;
      pm_rd_r     <= 1'b0;
      pm_addr_r   <= 16'h0000;
      jump_r      <= 1'b0;
      jump_addr_r <= 16'h0000;
      grant_idx_r <= 3'h0;
    end else begin
      gie_clr_r <= 1'b0;
      jump_r    <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (grant) begin
            grant_idx_r <= enc_idx;
            int_cycle_r <= 1'b1;
            gie_clr_r   <= 1'b1;  // see [R4]
            save_req_r  <= 1'b1;  // see [R5]
            state_r     <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          if (core_save_done) begin
            save_req_r <= 1'b0;
            pm_addr_r  <= {12'h000, grant_idx_r, 1'b0};  // see [R6]
            pm_rd_r    <= 1'b1;
            state_r    <= ST_FHI;
          end
        end
        ST_FHI: begin
          if (pm_valid) begin
            jump_addr_r[15:8] <= pm_data;
            pm_addr_r         <= pm_addr_r + 16'h0001;  // see [R6]
            state_r           <= ST_FLO;
          end
        end
        ST_FLO: begin
          if (pm_valid) begin
            jump_addr_r[7:0] <= pm_data;
            pm_rd_r          <= 1'b0;
            jump_r           <= 1'b1;  // see [R6]
            state_r          <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          int_cycle_r <= 1'b0;
          state_r     <= ST_IDLE;
        end
        default: begin
          int_cycle_r <= 1'b0;
          save_req_r  <= 1'b0;
          pm_rd_r     <= 1'b0;
          state_r     <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    rmapped   = 1'b1;
    case (ar_idx)
      `VUI_IDX_PRIO:     rdata_nxt = 32'h0000_0000;  // see [R11]
      `VUI_IDX_IRQ:      rdata_nxt = {24'h00_0000, irq_reg_r};  // see [R7]
      `VUI_IDX_REQ_EN:   rdata_nxt = {26'h000_0000, req_en_r};
      `VUI_IDX_CTRL:     rdata_nxt = {30'h0000_0000, ctrl_r};
      `VUI_IDX_LEVEL:    rdata_nxt = {27'h000_0000, sync2_r};  // see [R10]
      `VUI_IDX_INT_STAT: rdata_nxt = {29'h0000_0000, int_stat_r};
      `VUI_IDX_INT_MASK: rdata_nxt = {29'h0000_0000, int_mask_r};
      default:           rmapped   = 1'b0;
    endcase
  end

  // AXI4-Lite handshakes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `VUI_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `VUI_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_idx_r      <= 10'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped_w ? `VUI_RESP_OKAY : `VUI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_nxt;
        s_axi_rresp  <= rmapped ? `VUI_RESP_OKAY : `VUI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/vui_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module vui_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        core_gie,
  input wire logic        core_save_done,
  input wire logic        pm_valid,
  input wire logic [7:0]  pm_data,
  input wire logic        int_cycle_r,
  input wire logic        gie_clr_r,
  input wire logic        save_req_r,
  input wire logic        pm_rd_r,
  input wire logic [15:0] pm_addr_r,
  input wire logic        jump_r,
  input wire logic [15:0] jump_addr_r,
  input wire logic [2:0]  grant_idx_r,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] hi_r;
  // First vector byte, kept for the jump address
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      hi_r <= 8'h00;
    else if (pm_rd_r && pm_valid && !pm_addr_r[0])
      hi_r <= pm_data;
  end
  sequence fetch_hi_s;
    pm_rd_r && pm_valid && !pm_addr_r[0];
  endsequence
  sequence fetch_lo_s;
    pm_rd_r && pm_valid && pm_addr_r[0];
  endsequence
  entry_outputs_a: assert property (
    $rose(int_cycle_r) |-> gie_clr_r && save_req_r && !pm_rd_r)
    else $error("entry outputs wrong");
  gie_pulse_a: assert property (gie_clr_r |=> !gie_clr_r && int_cycle_r)
    else $error("gie clear not one cycle");
  no_grant_a: assert property (!int_cycle_r && !core_gie |=> !int_cycle_r)
    else $error("grant while disabled");
  save_hold_a: assert property (save_req_r && !core_save_done |=> save_req_r)
    else $error("save request dropped early");
  fetch_start_a: assert property (
    save_req_r && core_save_done |=>
      !save_req_r && pm_rd_r && pm_addr_r == {12'h000, grant_idx_r, 1'b0})
    else $error("first vector fetch wrong");
  fetch_step_a: assert property (
    fetch_hi_s |=> pm_rd_r && pm_addr_r == {12'h000, grant_idx_r, 1'b1})
    else $error("second vector fetch wrong");
  jump_after_a: assert property (fetch_lo_s |=> jump_r && !pm_rd_r)
    else $error("no jump after fetch");
  jump_addr_a: assert property (jump_r |-> jump_addr_r == {hi_r, $past(pm_data)})
    else $error("jump address wrong");
  cycle_end_a: assert property (jump_r |=> !int_cycle_r && !jump_r)
    else $error("cycle not closed");
  prio_hidden_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h3e4 |=>
      s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("priority readable");
endmodule
`default_nettype wire

// >>> verif/vui_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module vui_core_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        gie_en,
  input  wire logic        slow,
  input  wire logic        gie_clr_r,
  input  wire logic        jump_r,
  input  wire logic        save_req_r,
  input  wire logic        pm_rd_r,
  input  wire logic [15:0] pm_addr_r,
  output wire logic        core_gie,
  output logic             core_save_done,
  output logic             pm_valid,
  output logic [7:0]       pm_data
);
  logic       en_r;
  logic [1:0] wait_r;
  assign core_gie = gie_en & en_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b1;
      wait_r <= 2'd0;
      core_save_done <= 1'b0;
      pm_valid <= 1'b0;
      pm_data <= 8'h00;
    end else begin
      core_save_done <= 1'b0;
      pm_valid <= 1'b0;
      pm_data <= ~pm_data;
      if (gie_clr_r)
        en_r <= 1'b0;
      else if (jump_r)
        en_r <= 1'b1;
      if ((save_req_r || pm_rd_r) && !core_save_done && !pm_valid) begin
        if (wait_r == (slow ? 2'd3 : 2'd0)) begin
          wait_r <= 2'd0;
          if (save_req_r)
            core_save_done <= 1'b1;
          else begin
            pm_valid <= 1'b1;
            pm_data <= pm_addr_r[7:0] * 8'h1d ^ 8'h5a;
          end
        end else
          wait_r <= wait_r + 2'd1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/vectored_interrupt_unit_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "vui_map.vh"
module vectored_interrupt_unit_test;
  logic        clk, nrst, port3_line1, port3_line2, port3_line3, gie_en, slow;
  logic        comparator_one_input, comparator_two_input, core_ready, core_gie;
  logic        sixteen_bit_timer, eight_bit_timer, low_voltage_detector;
  logic        core_save_done, pm_valid, int_cycle_r, gie_clr_r, save_req_r, pm_rd_r;
  logic        jump_r, irq_r, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  grant_idx_r;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  pm_data;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] pm_addr_r, jump_addr_r;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          fails = 0;
  int          check_count = 0;
  vui_top dut (.clk, .nrst, .port3_line1, .port3_line2, .port3_line3, .comparator_one_input,
    .comparator_two_input, .sixteen_bit_timer, .eight_bit_timer, .low_voltage_detector,
    .core_gie, .core_ready, .core_save_done, .pm_valid, .pm_data, .int_cycle_r, .gie_clr_r,
    .save_req_r, .pm_rd_r, .pm_addr_r, .jump_r, .jump_addr_r, .grant_idx_r, .irq_r,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  vui_core_model core (.clk, .nrst, .gie_en, .slow, .gie_clr_r, .jump_r, .save_req_r,
    .pm_rd_r, .pm_addr_r, .core_gie, .core_save_done, .pm_valid, .pm_data);
  task end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  function logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction
  function logic [7:0] vb(input int a);
    return a[7:0] * 8'h1d ^ 8'h5a;
  endfunction
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  task pulse(input logic [2:0] m);
    @(posedge clk);
    {sixteen_bit_timer, eight_bit_timer, low_voltage_detector} <= m;
    @(posedge clk);
    {sixteen_bit_timer, eight_bit_timer, low_voltage_detector} <= 3'b000;
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    end_sim;
  end
  initial begin
    int k, j, p, e, pend;
    logic [1:0] sel;
    logic src, v;
    logic [2:0] hit;
    logic [31:0] d;
    logic [9:0] idx [8];
    idx = '{`VUI_IDX_PRIO, `VUI_IDX_IRQ, `VUI_IDX_REQ_EN, `VUI_IDX_CTRL, `VUI_IDX_LEVEL,
      `VUI_IDX_INT_STAT, `VUI_IDX_INT_MASK, 10'h000};
    {port3_line1, port3_line2, port3_line3, comparator_one_input, comparator_two_input} = 0;
    {sixteen_bit_timer, eight_bit_timer, low_voltage_detector, core_ready, slow} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_awaddr = 0;
    s_axi_araddr = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'hf;
    gie_en = 1;
    nrst = 0;
    repeat (5) @(posedge clk);
    nrst <= 1;
    void'($urandom(84));
    for (k = 0; k < 8; k++) begin
      rd(ad(idx[k]), k == 7 ? `VUI_RESP_SLVERR : `VUI_RESP_OKAY, d);
      chk("reset value", d, 32'h0000_0000);
    end
    wr(ad(`VUI_IDX_PRIO), 32'h0000_0005, `VUI_RESP_OKAY);
    rd(ad(`VUI_IDX_PRIO), `VUI_RESP_OKAY, d);
    chk("priority read", d, 32'h0000_0000);
    wr(ad(10'h000), 32'h0000_00ff, `VUI_RESP_SLVERR);
    // Lane 0 strobe low: answered OKAY, register untouched
    s_axi_wstrb <= 4'he;
    wr(ad(`VUI_IDX_CTRL), 32'h0000_0003, `VUI_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ad(`VUI_IDX_CTRL), `VUI_RESP_OKAY, d);
    chk("lane0 strobe", d, 32'h0000_0000);
    for (k = 0; k < 8; k++) begin
      sel = k[1:0];
      src = k[2];
      wr(ad(`VUI_IDX_CTRL), {30'd0, src, src}, `VUI_RESP_OKAY);
      for (j = 0; j < 2; j++) begin
        v = (j == 0);
        wr(ad(`VUI_IDX_IRQ), {24'd0, sel, 6'd0}, `VUI_RESP_OKAY);
        if (src)
          {comparator_one_input, comparator_two_input} <= {v, v};
        else
          {port3_line1, port3_line2} <= {v, v};
        port3_line3 <= v;
        repeat (5) @(posedge clk);
        hit = v ? {sel[1], 1'b0, sel[0]} : {~sel[1] | &sel, 1'b1, ~sel[0] | &sel};
        rd(ad(`VUI_IDX_IRQ), `VUI_RESP_OKAY, d);
        chk("edge pending", d, {24'd0, sel, 3'd0, hit});
        rd(ad(`VUI_IDX_LEVEL), `VUI_RESP_OKAY, d);
        chk("pin level", d, src ? {27'd0, v, v, v, 2'd0} : {27'd0, 2'd0, v, v, v});
      end
    end
    wr(ad(`VUI_IDX_IRQ), 32'h0000_0000, `VUI_RESP_OKAY);
    core_ready <= 1'b1;
    pulse(3'b111);
    pulse(3'b100);
    repeat (3) @(posedge clk);
    chk("masked grant", 32'(int_cycle_r), 32'h0000_0000);
    rd(ad(`VUI_IDX_IRQ), `VUI_RESP_OKAY, d);
    chk("polled pending", d, 32'h0000_0038);
    rd(ad(`VUI_IDX_INT_STAT), `VUI_RESP_OKAY, d);
    chk("overrun", d, 32'h0000_0004);
    core_ready <= 1'b0;
    wr(ad(`VUI_IDX_IRQ), 32'h0000_003f, `VUI_RESP_OKAY);
    wr(ad(`VUI_IDX_REQ_EN), 32'h0000_003f, `VUI_RESP_OKAY);
    pend = 32'h3f;
    for (k = 0; k < 6; k++) begin
      p = $urandom % 8;
      slow <= 1'($urandom);
      wr(ad(`VUI_IDX_PRIO), 32'(p), `VUI_RESP_OKAY);
      e = p > 5 ? 0 : p;
      while (!pend[e])
        e = (e + 1) % 6;
      core_ready <= 1'b1;
      do @(posedge clk); while (!jump_r);
      core_ready <= 1'b0;
      chk("grant", 32'(grant_idx_r), 32'(e));
      d = {16'd0, vb(2 * e), vb(2 * e + 1)};
      chk("vector", 32'(jump_addr_r), d);
      pend[e] = 0;
      rd(ad(`VUI_IDX_IRQ), `VUI_RESP_OKAY, d);
      chk("pending", d, 32'(pend));
    end
    gie_en <= 1'b0;
    wr(ad(`VUI_IDX_IRQ), 32'h0000_0020, `VUI_RESP_OKAY);
    core_ready <= 1'b1;
    repeat (10) @(posedge clk);
    chk("disabled grant", 32'(int_cycle_r), 32'h0000_0000);
    gie_en <= 1'b1;
    do @(posedge clk); while (!jump_r);
    core_ready <= 1'b0;
    chk("late grant", 32'(grant_idx_r), 32'h0000_0005);
    chk("irq masked", 32'(irq_r), 32'h0000_0000);
    wr(ad(`VUI_IDX_INT_MASK), 32'h0000_0004, `VUI_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'(irq_r), 32'h0000_0001);
    wr(ad(`VUI_IDX_INT_STAT), 32'h0000_0004, `VUI_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'(irq_r), 32'h0000_0000);
    rd(ad(`VUI_IDX_INT_STAT), `VUI_RESP_OKAY, d);
    chk("status left", d, 32'h0000_0003);
    end_sim;
  end
endmodule
bind vui_top vui_chk chk_i (.clk, .nrst, .core_gie, .core_save_done, .pm_valid, .pm_data,
  .int_cycle_r, .gie_clr_r, .save_req_r, .pm_rd_r, .pm_addr_r, .jump_r, .jump_addr_r,
  .grant_idx_r, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid);
`default_nettype wire
